// ---- include/fsl_pkg.sv ----
// Constants shared by the flash command-decoder end and the SPI host end.
// Assumes single-bit SPI, mode 0, serial clock made by the host from core_clk_in.
// How it works
// - Read secure: 48h, address, eight dummies.
// - Device samples input on rising edge.
// - Data out MSB first on falling.
// - Byte pointer wraps FFh to 00h.
// - Read ends only on select rising.
// - Secure read ignored while busy.
// - Address 15..12 picks register one-three.
// - Lock bits act only when scheme set.
// - Lock bits volatile, all one at reset.
// - 36h plus address locks one unit.
// - 39h plus address unlocks one unit.
// - Lock commands need write enable latch.
// - 3Dh plus address returns lock value.
// - Returned LSB one means locked.
// - 7Eh sets every lock bit.
// - 98h clears every lock bit.
// - Reset returns volatile state to power-on.
// - Reset needs 66h then 99h directly.
// - Commands rejected for 30 us after reset.
// - Host checks busy and paused first; fsl_host checks neither.
package fsl_pkg;
   localparam logic [7:0] OP_SEC_READ    = 8'h48;
   localparam logic [7:0] OP_LOCK_ONE    = 8'h36;
   localparam logic [7:0] OP_UNLOCK_ONE  = 8'h39;
   localparam logic [7:0] OP_LOCK_READ   = 8'h3D;
   localparam logic [7:0] OP_LOCK_ALL    = 8'h7E;
   localparam logic [7:0] OP_UNLOCK_ALL  = 8'h98;
   localparam logic [7:0] OP_RESET_ARM   = 8'h66;
   localparam logic [7:0] OP_RESET_GO    = 8'h99;
   localparam logic [7:0] OP_WRITE_EN    = 8'h06;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   localparam int         ADDR_BITS      = 24;
   localparam int         DUMMY_BITS     = 8;
   localparam int         CLK_PERIOD_NS  = 100;
   localparam int         RESET_REC_US   = 30;
   localparam int         RESET_REC_CYC  = (RESET_REC_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         NUM_UNITS      = 64;
   localparam int         UNIT_SHIFT     = 15;
   localparam logic       LOCK_RESET     = 1'b1;
   localparam int         SCK_HALF_CYC   = 1;
   // Host register offsets on the APB side.
   localparam logic [7:0] REG_CMD        = 8'h00;
   localparam logic [7:0] REG_ADDR       = 8'h04;
   localparam logic [7:0] REG_CTRL       = 8'h08;
   localparam logic [7:0] REG_STATUS     = 8'h0C;
   localparam logic [7:0] REG_RDATA      = 8'h10;
   localparam int         CTRL_GO_BIT    = 0;
   localparam int         CTRL_ADDR_BIT  = 1;
   localparam int         CTRL_DUMMY_BIT = 2;
   localparam int         CTRL_NRD_LSB   = 8;
endpackage : fsl_pkg

// ---- include/fsl_if.sv ----
// Single-bit SPI bus between the host end and the flash end.
// Assumes both ends share core_clk_in; the serial clock is a plain signal.
`timescale 1ns/100ps
interface fsl_if;
   logic cs_n;
   logic sck;
   logic serial_in;
   logic serial_out;
   logic serial_out_oe;
   modport host   (output cs_n, output sck, output serial_in, input serial_out, input serial_out_oe);
   modport device (input cs_n, input sck, input serial_in, output serial_out, output serial_out_oe);
endinterface : fsl_if

// ---- design/fsl_device.sv ----
// Flash command decoder: security register read, volatile lock bits, software reset.
// Assumes SPI pins synchronous to core_clk_in, serial clock slower than core clock.
`timescale 1ns/100ps
module fsl_device #(
   parameter int RESET_REC = fsl_pkg::RESET_REC_CYC
) (
   // Clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        srst_in,
   // Link
   fsl_if.device            spi,
   // Rest of the unit
   input  wire logic        busy_in,
   input  wire logic        write_protect_scheme_in,
   input  wire logic        range_protected_in,
   input  wire logic [15:0] prot_check_unit_in,
   output logic             prot_check_locked_out,
   output logic             write_enable_latch_out,
   output logic             sw_reset_out,
   output logic             recovering_out,
   output logic [7:0]       secreg_raddr_out,
   output logic [1:0]       secreg_sel_out,
   input  wire logic [7:0]  secreg_rdata_in
);

   // ----------------------------------------------------------------
   // State and storage
   // ----------------------------------------------------------------
   // Lock bits live in flops: they are volatile and any reset sets them all again.
   typedef enum {ST_OP, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} fsl_state_t;
   fsl_state_t  state_q;
   logic        sck_q;
   logic        cs_q;
   logic [7:0]  sh_q;
   logic [23:0] addr_q;
   logic [5:0]  cnt_q;
   logic [7:0]  op_q;
   logic [7:0]  out_q;
   logic [7:0]  ptr_q;
   logic        oe_q;
   logic        wel_q;
   logic        arm_q;
   logic [15:0] rec_q;
   logic [2:0]  bit_q;
   logic [fsl_pkg::NUM_UNITS-1:0] lock_q;

   // ----------------------------------------------------------------
   // Edge detection and decode
   // ----------------------------------------------------------------
   // Edges are seen one core cycle late, so the serial clock can run at most at half the core clock, as the host drives it.
   // A select rising ends any command, whole or cut.
   wire  rise      = spi.sck & ~sck_q & ~spi.cs_n;
   wire  fall      = ~spi.sck & sck_q & ~spi.cs_n;
   wire  cs_rise   = spi.cs_n & ~cs_q;
   wire  [7:0] shn = {sh_q[6:0], spi.serial_in};
   wire  [23:0] adn = {addr_q[22:0], spi.serial_in};
   wire  byte_done = rise & (cnt_q == 6'd7);
   wire  addr_done = rise & (cnt_q == 6'(fsl_pkg::ADDR_BITS - 1));
   wire  dum_done  = rise & (cnt_q == 6'(fsl_pkg::DUMMY_BITS - 1));
   wire  recovering = (rec_q != 16'h0000);
   wire  [5:0] unit = addr_q[fsl_pkg::UNIT_SHIFT +: 6];
   wire  sec_ok = (adn[23:16] == 8'h00) & (adn[11:8] == 4'h0) & (adn[15:12] >= 4'h1) & (adn[15:12] <= 4'h3);
   wire  lock_op = (op_q == fsl_pkg::OP_LOCK_ONE) | (op_q == fsl_pkg::OP_UNLOCK_ONE)
                 | (op_q == fsl_pkg::OP_LOCK_ALL) | (op_q == fsl_pkg::OP_UNLOCK_ALL);
   wire  [7:0] next_byte = (op_q == fsl_pkg::OP_LOCK_READ) ? {7'h00, lock_q[unit]} : secreg_rdata_in;

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // The protect check is combinational so the array side sees a lock change at once.
   // scheme select
   assign prot_check_locked_out = write_protect_scheme_in ? lock_q[prot_check_unit_in[5:0]] : range_protected_in;
   assign write_enable_latch_out = wel_q;
   assign recovering_out = recovering;
   assign secreg_raddr_out = ptr_q;
   assign secreg_sel_out = addr_q[13:12];
   assign spi.serial_out = out_q[7];
   assign spi.serial_out_oe = oe_q;

   // ----------------------------------------------------------------
   // Pin sampling
   // ----------------------------------------------------------------
   // The pins are taken as synchronous, so one flop per pin is enough.
   always_ff @(posedge core_clk_in) begin
      sck_q <= spi.sck;
      cs_q  <= spi.cs_n;
   end

   // ----------------------------------------------------------------
   // Command shifter
   // ----------------------------------------------------------------
   // A raised select clears the shifter at once, so no cut frame leaves state behind.
   // Lock and unlock of one unit wait in the ignore state after the address until select rises.
   // rising sample
   always_ff @(posedge core_clk_in) begin
      if (srst_in | sw_reset_out | spi.cs_n) begin
         state_q <= ST_OP;
         cnt_q   <= 6'd0;
         sh_q    <= 8'h00;
         op_q    <= 8'h00;
         addr_q  <= 24'h000000;
      end else if (rise) begin
         cnt_q <= cnt_q + 6'd1;
         case (state_q)
            ST_OP: begin
               sh_q <= shn;
               if (byte_done) begin
                  op_q  <= shn;
                  cnt_q <= 6'd0;
                  if (recovering || (shn == fsl_pkg::OP_SEC_READ && busy_in)) state_q <= ST_IGNORE;
                  else if (shn == fsl_pkg::OP_SEC_READ || shn == fsl_pkg::OP_LOCK_ONE
                           || shn == fsl_pkg::OP_UNLOCK_ONE || shn == fsl_pkg::OP_LOCK_READ) state_q <= ST_ADDR;
                  else state_q <= ST_IGNORE;
               end
            end
            ST_ADDR: begin
               addr_q <= adn;
               if (addr_done) begin
                  cnt_q <= 6'd0;
                  if (op_q == fsl_pkg::OP_SEC_READ) state_q <= sec_ok ? ST_DUMMY : ST_IGNORE;
                  else if (op_q == fsl_pkg::OP_LOCK_READ) state_q <= ST_DATA;
                  else state_q <= ST_IGNORE;
               end
            end
            ST_DUMMY: if (dum_done) begin
               cnt_q   <= 6'd0;
               state_q <= ST_DATA;
            end
            default: cnt_q <= 6'd0;
         endcase
      end
   end
   // falling shift
   // The first byte loads on the first fall in the data state (after the dummies, or after the address for 3Dh), ready for the next rise.
   always_ff @(posedge core_clk_in) begin
      if (srst_in | spi.cs_n | (state_q != ST_DATA)) begin
         oe_q  <= 1'b0;
         out_q <= 8'h00;
         bit_q <= 3'h0;
         ptr_q <= srst_in ? 8'h00 : (state_q == ST_DUMMY) ? addr_q[7:0] : ptr_q;
      end else if (fall) begin
         oe_q <= 1'b1;
         if (!oe_q || bit_q == 3'h7) begin
            out_q <= next_byte;
            ptr_q <= ptr_q + 8'h01;
            bit_q <= 3'h0;
         end else begin
            out_q <= {out_q[6:0], 1'b0};
            bit_q <= bit_q + 3'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Write enable latch, reset arming and recovery
   // ----------------------------------------------------------------
   // Arming survives only one whole command; anything else but a frame cut inside its opcode drops it.
   // reset pair
   assign sw_reset_out = cs_rise & (state_q == ST_IGNORE) & (op_q == fsl_pkg::OP_RESET_GO) & arm_q & (cnt_q == 6'd0);
   always_ff @(posedge core_clk_in) begin
      if (srst_in | sw_reset_out) begin
         arm_q <= 1'b0;
         wel_q <= 1'b0;
         // Recovery counts core cycles; the default covers the whole recovery time.
         // recovery
         rec_q <= sw_reset_out ? 16'(RESET_REC) : 16'h0000;
      end else begin
         if (recovering) rec_q <= rec_q - 16'h0001;
         if (cs_rise && state_q == ST_IGNORE && cnt_q == 6'd0 && !recovering) begin
            arm_q <= (op_q == fsl_pkg::OP_RESET_ARM);
            if (op_q == fsl_pkg::OP_WRITE_EN) wel_q <= 1'b1;
            if (lock_op) wel_q <= 1'b0;
         end else if (cs_rise && op_q != 8'h00) begin
            arm_q <= 1'b0;
            if (lock_op) wel_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Lock bits
   // ----------------------------------------------------------------
   // Lock bits change only at select rising, so a cut frame leaves them alone.
   // Bits are volatile: any reset sets all of them to locked.
   // all locked
   always_ff @(posedge core_clk_in) begin
      if (srst_in | sw_reset_out) begin
         lock_q <= {fsl_pkg::NUM_UNITS{fsl_pkg::LOCK_RESET}};
      end else if (cs_rise && wel_q && !recovering) begin
         if (op_q == fsl_pkg::OP_LOCK_ONE && state_q == ST_IGNORE && cnt_q == 6'd0) lock_q[unit] <= 1'b1;
         if (op_q == fsl_pkg::OP_UNLOCK_ONE && state_q == ST_IGNORE && cnt_q == 6'd0) lock_q[unit] <= 1'b0;
         if (op_q == fsl_pkg::OP_LOCK_ALL && state_q == ST_IGNORE && cnt_q == 6'd0) lock_q <= '1;
         if (op_q == fsl_pkg::OP_UNLOCK_ALL && state_q == ST_IGNORE && cnt_q == 6'd0) lock_q <= '0;
      end
   end
endmodule : fsl_device

// ---- design/fsl_host.sv ----
// SPI host end: APB registers hold opcode, address and control; it frames one command.
// Assumes one clock; the serial clock is a divided level driven out.
`timescale 1ns/100ps
module fsl_host (
   // Clock and reset
   input  wire logic        core_clk_in,
   input  wire logic        srst_in,
   // APB
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Link
   fsl_if.host              spi
);
   typedef enum {H_IDLE, H_SHIFT, H_END} fsl_hstate_t;
   fsl_hstate_t state_q;
   logic [7:0]  cmd_q;
   logic [23:0] addr_q;
   logic [31:0] ctrl_q;
   logic [31:0] rdata_q;
   logic [47:0] tx_q;
   logic [9:0]  bits_q;
   logic        sck_q;
   logic        cs_n_q;
   logic [31:0] prdata_q;
   wire  acc   = psel_in & penable_in;
   wire  wr    = acc & pwrite_in;
   wire  go    = wr & (paddr_in == fsl_pkg::REG_CTRL) & pwdata_in[fsl_pkg::CTRL_GO_BIT] & (state_q == H_IDLE);
   wire  [9:0] nbits = 10'd8 + (ctrl_q[fsl_pkg::CTRL_ADDR_BIT] ? 10'd24 : 10'd0)
                     + (ctrl_q[fsl_pkg::CTRL_DUMMY_BIT] ? 10'd8 : 10'd0) + {ctrl_q[fsl_pkg::CTRL_NRD_LSB +: 5], 3'b000};
   wire  mapped = (paddr_in == fsl_pkg::REG_CMD) | (paddr_in == fsl_pkg::REG_ADDR) | (paddr_in == fsl_pkg::REG_CTRL)
                | (paddr_in == fsl_pkg::REG_STATUS) | (paddr_in == fsl_pkg::REG_RDATA);
   assign pready_out  = 1'b1;
   assign pslverr_out = acc & ~mapped;
   assign prdata_out  = prdata_q;
   assign spi.cs_n = cs_n_q;
   assign spi.sck = sck_q;
   assign spi.serial_in = tx_q[47];
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         cmd_q <= 8'h00;
         addr_q <= 24'h000000;
         ctrl_q <= 32'h00000000;
      end else if (wr) begin
         if (paddr_in == fsl_pkg::REG_CMD) cmd_q <= pwdata_in[7:0];
         if (paddr_in == fsl_pkg::REG_ADDR) addr_q <= pwdata_in[23:0];
         if (paddr_in == fsl_pkg::REG_CTRL) ctrl_q <= {pwdata_in[31:1], 1'b0};
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (srst_in) prdata_q <= 32'h00000000;
      else if (psel_in && !penable_in) begin
         case (paddr_in)
            fsl_pkg::REG_CMD:    prdata_q <= {24'h000000, cmd_q};
            fsl_pkg::REG_ADDR:   prdata_q <= {8'h00, addr_q};
            fsl_pkg::REG_CTRL:   prdata_q <= ctrl_q;
            fsl_pkg::REG_STATUS: prdata_q <= {31'h00000000, state_q != H_IDLE};
            fsl_pkg::REG_RDATA:  prdata_q <= rdata_q;
            default:             prdata_q <= 32'h00000000;
         endcase
      end
   end
   always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
         state_q <= H_IDLE;
         cs_n_q <= 1'b1;
         sck_q <= 1'b0;
         tx_q <= 48'h000000000000;
         bits_q <= 10'd0;
         rdata_q <= 32'h00000000;
      end else begin
         case (state_q)
            H_IDLE: if (go) begin
               cs_n_q <= 1'b0;
               tx_q <= {cmd_q, addr_q, 16'h0000};
               bits_q <= 10'd0;
               state_q <= H_SHIFT;
            end
            H_SHIFT: begin
               sck_q <= ~sck_q;
               // late sample
               // The flash end answers one core cycle after each fall, so data is taken at the end of the high phase.
               if (sck_q) begin
                  rdata_q <= {rdata_q[30:0], spi.serial_out};
                  tx_q <= {tx_q[46:0], 1'b0};
                  bits_q <= bits_q + 10'd1;
                  if (bits_q == nbits - 10'd1) state_q <= H_END;
               end
            end
            H_END: begin
               cs_n_q <= 1'b1;
               state_q <= H_IDLE;
            end
            default: state_q <= H_IDLE;
         endcase
      end
   end
endmodule : fsl_host

// ---- testbench/fsl_chk.sv ----
// Checker on the SPI link between the host end and the flash end.
// Assumes every link signal is sampled on core_clk_in.
`timescale 1ns/100ps
module fsl_chk (
   // Clock and reset
   input  wire logic core_clk_in,
   input  wire logic srst_in,
   // Link
   input  wire logic cs_n,
   input  wire logic sck,
   input  wire logic serial_in,
   input  wire logic serial_out,
   input  wire logic serial_out_oe
);
   logic        sck_q;
   logic [15:0] rise_q;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (srst_in);
   always_ff @(posedge core_clk_in) begin
      sck_q <= sck;
      if (srst_in || cs_n) rise_q <= 16'h0000;
      else if (sck && !sck_q) rise_q <= rise_q + 16'h0001;
   end
   a_idle_sck_low: assert property (cs_n && $past(cs_n) |-> !sck) else $error("sck moved while deselected");
   a_idle_out_off: assert property (cs_n && $past(cs_n) |-> !serial_out_oe) else $error("output driven while deselected");
   a_open_sck_low: assert property ($fell(cs_n) |-> !sck) else $error("frame opened with sck high");
   a_in_on_low: assert property (!cs_n && $changed(serial_in) |-> !sck) else $error("input changed with sck high");
   a_out_on_fall: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out) |-> !$past(sck))
      else $error("output changed off the falling edge");
   a_whole_bytes: assert property ($rose(cs_n) |-> rise_q[2:0] == 3'h0) else $error("frame not whole bytes");
   a_out_after_addr: assert property ($rose(serial_out_oe) |-> rise_q >= 16'h0020) else $error("output before address end");
   a_stream_to_cs: assert property ($fell(serial_out_oe) |-> cs_n || $past(cs_n)) else $error("stream stopped early");
endmodule : fsl_chk

// ---- testbench/fsl_tb.sv ----
// Bench for the host end and the flash end joined on one link.
// Assumes the host answers APB at once and frames one command per go write.
`timescale 1ns/100ps
module fsl_tb;
   // Short recovery keeps the run brief; expectations use the same value.
   localparam int REC = 60;
   logic        core_clk, srst, psel, penable, pwrite, busy, write_protect_scheme, rprot, p_rdy, p_err, lk_out, wel_out, sw_rst, recov, e;
   logic [7:0]  paddr, s_addr, s_rd, o;
   logic [1:0]  s_sel;
   logic [15:0] unit;
   logic [31:0] pwdata, prdata, rd;
   int          fails, comparisons, locks[64], write_enable_latch, armed, deaf, rc, oe_seen, pulses, u, s, n;
   fsl_if link ();
   fsl_host u_fsl_host (.core_clk_in(core_clk), .srst_in(srst), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(p_rdy),
      .pslverr_out(p_err), .spi(link));
   fsl_device #(.RESET_REC(REC)) u_fsl_device (.core_clk_in(core_clk), .srst_in(srst), .spi(link),
      .busy_in(busy), .write_protect_scheme_in(write_protect_scheme), .range_protected_in(rprot), .prot_check_unit_in(unit),
      .prot_check_locked_out(lk_out), .write_enable_latch_out(wel_out), .sw_reset_out(sw_rst),
      .recovering_out(recov), .secreg_raddr_out(s_addr), .secreg_sel_out(s_sel), .secreg_rdata_in(s_rd));
   fsl_chk u_fsl_chk (.core_clk_in(core_clk), .srst_in(srst), .cs_n(link.cs_n), .sck(link.sck),
      .serial_in(link.serial_in), .serial_out(link.serial_out), .serial_out_oe(link.serial_out_oe));
   function automatic logic [7:0] pat(input logic [1:0] sl, input logic [7:0] a);
      return a ^ {sl, 6'h2D};
   endfunction : pat
   assign s_rd = pat(s_sel, s_addr);
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      if (link.serial_out_oe === 1'b1) oe_seen <= 1;
      if (sw_rst === 1'b1) pulses <= pulses + 1;
      rc <= (sw_rst === 1'b1) ? 0 : rc + ((recov === 1'b1) ? 1 : 0);
   end
   task automatic wrap_up;
      if (fails == 0 && comparisons > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : wrap_up
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         fails++;
         $display("unexpected %s expected %h seen %h", nm, x, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int k;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge core_clk);
         if (p_rdy === 1'b1) break;
      end
      if (k == 50) begin
         fails++;
         wrap_up();
      end
      r = prdata;
      e = p_err;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic frame(input logic [7:0] op, input logic [23:0] ad = 0, input int fl = 0, input int nb = 0);
      logic [31:0] st;
      logic        lk;
      int          k;
      lk = op inside {fsl_pkg::OP_LOCK_ONE, fsl_pkg::OP_UNLOCK_ONE, fsl_pkg::OP_LOCK_ALL, fsl_pkg::OP_UNLOCK_ALL};
      oe_seen = 0;
      apb(1'b1, fsl_pkg::REG_CMD, {24'h000000, op}, st);
      apb(1'b1, fsl_pkg::REG_ADDR, {8'h00, ad}, st);
      apb(1'b1, fsl_pkg::REG_CTRL, 32'(nb << 8) | 32'(fl) | 32'h00000001, st);
      st = 32'h00000001;
      for (k = 0; k < 400 && st[0] !== 1'b0; k++) apb(1'b0, fsl_pkg::REG_STATUS, 32'h00000000, st);
      if (st[0] !== 1'b0) begin
         fails++;
         wrap_up();
      end
      apb(1'b0, fsl_pkg::REG_RDATA, 32'h00000000, rd);
      if (deaf == 0 && op == fsl_pkg::OP_RESET_GO && armed != 0) begin
         foreach (locks[i]) locks[i] = 1;
         write_enable_latch = 0;
         deaf = 1;
      end
      armed = (deaf == 0 && op == fsl_pkg::OP_RESET_ARM);
      if (deaf == 0 && lk && write_enable_latch != 0) begin
         if (op == fsl_pkg::OP_LOCK_ONE || op == fsl_pkg::OP_UNLOCK_ONE) locks[ad[20:15]] = (op == fsl_pkg::OP_LOCK_ONE);
         else foreach (locks[i]) locks[i] = (op == fsl_pkg::OP_LOCK_ALL);
      end
      if (deaf == 0 && lk) write_enable_latch = 0;
      if (deaf == 0 && op == fsl_pkg::OP_WRITE_EN) write_enable_latch = 1;
      chk("latch", 32'(write_enable_latch), {31'h0, wel_out});
   endtask : frame
   task automatic lock_chk(input int un);
      logic w;
      logic r;
      w = 1'($urandom);
      r = 1'($urandom);
      frame(fsl_pkg::OP_LOCK_READ, 24'(un) << 15, 2, 1);
      chk("lock_bit", 32'(locks[un]), {31'h0, rd[0]});
      unit <= 16'(un);
      write_protect_scheme <= w;
      rprot <= r;
      @(posedge core_clk);
      chk("prot", {31'h0, w ? 1'(locks[un]) : r}, {31'h0, lk_out});
   endtask : lock_chk
   initial begin
      {psel, penable, pwrite, busy, write_protect_scheme, rprot, e} = '0;
      {paddr, pwdata, unit} = '0;
      {fails, comparisons, write_enable_latch, armed, deaf, oe_seen, pulses, rc} = '0;
      foreach (locks[i]) locks[i] = 1;
      srst = 1'b1;
      void'($urandom(97833));
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      lock_chk(5);
      frame(fsl_pkg::OP_UNLOCK_ALL);
      lock_chk(5);
      frame(fsl_pkg::OP_WRITE_EN);
      frame(fsl_pkg::OP_UNLOCK_ALL);
      u = $urandom % 64;
      lock_chk(u);
      frame(fsl_pkg::OP_WRITE_EN);
      frame(fsl_pkg::OP_LOCK_ONE, 24'(u) << 15, 2);
      lock_chk(u);
      lock_chk((u + 1) % 64);
      frame(fsl_pkg::OP_WRITE_EN);
      frame(fsl_pkg::OP_UNLOCK_ONE, 24'(u) << 15, 2);
      lock_chk(u);
      frame(fsl_pkg::OP_WRITE_EN);
      frame(fsl_pkg::OP_LOCK_ALL);
      lock_chk((u + 7) % 64);
      for (s = 1; s < 4; s++) begin
         o = 8'hFD + 8'($urandom % 3);
         frame(fsl_pkg::OP_SEC_READ, {8'h00, 4'(s), 4'h0, o}, 6, 4);
         chk("sec_data", {pat(2'(s), o), pat(2'(s), o + 8'h01), pat(2'(s), o + 8'h02), pat(2'(s), o + 8'h03)}, rd);
      end
      busy <= 1'b1;
      frame(fsl_pkg::OP_SEC_READ, 24'h001000, 6, 2);
      chk("busy_out", 32'h0, 32'(oe_seen));
      busy <= 1'b0;
      frame(fsl_pkg::OP_SEC_READ, 24'h004000, 6, 2);
      chk("bad_sel_out", 32'h0, 32'(oe_seen));
      apb(1'b0, 8'h20, 32'h00000000, rd);
      chk("pslverr", 32'h1, {31'h0, e});
      frame(fsl_pkg::OP_WRITE_EN);
      frame(fsl_pkg::OP_UNLOCK_ALL);
      frame(fsl_pkg::OP_RESET_ARM);
      frame(fsl_pkg::OP_WRITE_EN);
      frame(fsl_pkg::OP_RESET_GO);
      chk("reset_pulses", 32'h0, 32'(pulses));
      lock_chk(3);
      frame(fsl_pkg::OP_RESET_ARM);
      frame(fsl_pkg::OP_RESET_GO);
      chk("reset_pulses", 32'h1, 32'(pulses));
      frame(fsl_pkg::OP_WRITE_EN);
      for (n = 0; n < 300 && recov !== 1'b0; n++) @(posedge core_clk);
      if (n == 300) begin
         fails++;
         wrap_up();
      end
      chk("recovery", 32'h1, 32'(rc >= REC - 1 && rc <= REC + 1));
      deaf = 0;
      frame(fsl_pkg::OP_UNLOCK_ALL);
      lock_chk(3);
      wrap_up();
   end
endmodule : fsl_tb
